// File: hdl/dinmap_pkg.sv
package dinmap_pkg;

  localparam int NumInputs = 6;
  localparam int FnWidth = 5;

  // function codes of each digital input
  typedef enum logic [4:0] {
    FnNone = 5'd0,
    FnStartStop = 5'd1,
    FnStart3w = 5'd2,
    FnStop3w = 5'd3,
    FnGenEnable = 5'd4,
    FnLocRem = 5'd5,
    FnJog = 5'd6,
    FnFwdRev = 5'd7,
    FnNoExtFault = 5'd8,
    FnNoExtAlarm = 5'd9,
    FnBrake = 5'd10,
    FnReset = 5'd11,
    FnLoadUser = 5'd12,
    FnEmergency = 5'd14,
    FnThermAlarm = 5'd15,
    FnThermFault = 5'd16
  } dinmap_fn_t;

  // command source code meaning "digital inputs"
  localparam logic [2:0] CmdSrcDigital = 3'h1;
  // user memory action codes that mark a saved memory
  localparam logic [2:0] ActSaveMem1 = 3'h4;
  localparam logic [2:0] ActSaveMem2 = 3'h5;

  // thermistor thresholds in ohm, for reference by the comparator front end
  localparam int ThermTripOhm = 3900;
  localparam int ThermReleaseOhm = 1600;
  localparam int ThermShortOhm = 100;

  // register byte addresses
  localparam logic [11:0] AddrFnSel0 = 12'h000;
  localparam logic [11:0] AddrCmdCfg = 12'h018;
  localparam logic [11:0] AddrStatus = 12'h01C;
  localparam logic [11:0] AddrInputs = 12'h020;

  // reset values of the function selects
  localparam logic [4:0] RstFnSel1 = 5'h02;
  localparam logic [4:0] RstFnSel2 = 5'h03;
  localparam logic [4:0] RstFnSelOther = 5'h00;

  // command configuration field positions
  localparam int CfgLocSrcLsb = 0;
  localparam int CfgRemSrcLsb = 4;
  localparam int CfgSaved1Bit = 8;
  localparam int CfgSaved2Bit = 9;

  // bundled outputs to the starter logic
  typedef struct packed {
    logic runCmd;
    logic start3wPulse;
    logic stop3wPulse;
    logic fastStop;
    logic remoteSel;
    logic jog;
    logic fwdContactor;
    logic revContactor;
    logic extFault;
    logic extAlarm;
    logic brakeAllow;
    logic faultReset;
    logic loadUser1;
    logic loadUser2;
    logic emergencyRun;
    logic thermAlarm;
    logic thermFault;
    logic thermShort;
  } dinmap_cmd_t;

endpackage

// File: hdl/dinmap_top.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - closed start/stop input starts, open stops
// - command source one means digital inputs
// - three-wire start fires on closing edge
// - three-wire stop fires on opening edge
// - enable open stops at once, no ramp
// - assigned enable must be closed to start
// - local/remote input open local, closed remote
// - jog active while any jog input closed
// - forward/reverse input steers two contactors
// - open no-fault input raises external fault
// - open no-alarm input shows alarm only
// - brake allowed only if all brake inputs closed
// - reset pulses once per closing edge
// - rising load edge loads saved memory one
// - falling load edge loads saved memory two
// - memory load ignored while motor enabled
// - emergency start bypasses protections and source
// - thermistor trips, releases, reports short
// - code zero only shows in input status
module dinmap_top
  import dinmap_pkg::*;
#(
  parameter int NIn = NumInputs
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NIn-1:0] digitalInputN,
  input wire logic thermOverTrip,
  input wire logic thermUnderRelease,
  input wire logic thermUnderShort,
  input wire logic motorEnabled,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dinmap_cmd_t cmd
);

  // synchroniser stages and the previous level for edge detection
  logic [NIn-1:0] inMeta_q;
  logic [NIn-1:0] inSync_q;
  logic [NIn-1:0] inPrev_q;
  logic [2:0] thMeta_q;
  logic [2:0] thSync_q;
  logic thTripped_q;

  // software configuration
  logic [FnWidth-1:0] fnSel_q [NIn];
  logic [2:0] locSrc_q;
  logic [2:0] remSrc_q;
  logic saved1_q;
  logic saved2_q;

  // bus answer and output registers
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  dinmap_cmd_t cmd_q;
  dinmap_cmd_t cmd_d;

  // decode helpers shared by the command processes
  logic remoteNow;
  logic cmdFromDi;
  logic anyEnable;
  logic enableOk;

  // bus side
  logic access;
  logic [31:0] rdMux;
  logic addrOk;

  // true when input idx is configured for function f
  function automatic logic isFn(input logic [FnWidth-1:0] sel,
                                input dinmap_fn_t f);
    isFn = (sel == FnWidth'(f));
  endfunction

  // byte address of function select register idx
  function automatic logic [11:0] fnAddr(input int idx);
    fnAddr = AddrFnSel0 + 12'(idx * 4);
  endfunction

  // closing transition, judged on synchronised levels
  function automatic logic closedEdge(input logic now, input logic was);
    closedEdge = now & !was;
  endfunction

  // opening transition, judged on synchronised levels
  function automatic logic openedEdge(input logic now, input logic was);
    openedEdge = !now & was;
  endfunction

  // true when a command source code selects the digital inputs
  function automatic logic srcIsDigital(input logic [2:0] src);
    srcIsDigital = (src == CmdSrcDigital);
  endfunction

  // two-stage synchroniser; edges are judged on the second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inMeta_q <= '0;
      inSync_q <= '0;
      inPrev_q <= '0;
    end else begin
      inMeta_q <= digitalInputN;
      inSync_q <= inMeta_q;
      inPrev_q <= inSync_q;
    end
  end

  // comparator levels are asynchronous too, so they get the same two stages
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thMeta_q <= '0;
      thSync_q <= '0;
    end else begin
      thMeta_q <= {thermUnderShort, thermUnderRelease, thermOverTrip};
      thSync_q <= thMeta_q;
    end
  end

  // thermistor hysteresis: trip above the high threshold, release only
  // inside the window; a short also reads as under release, so release
  // waits for the short comparator to drop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thTripped_q <= 1'b0;
    end else if (thSync_q[0]) begin
      thTripped_q <= 1'b1;
    end else if (thSync_q[1] && !thSync_q[2]) begin
      thTripped_q <= 1'b0;
    end
  end

  // the one local/remote input picks the mode; local when none is assigned
  always_comb begin
    remoteNow = 1'b0;
    for (int i = 0; i < NIn; i++) begin
      // code zero and reserved codes fall through with no action
      unique case (fnSel_q[i])
        FnWidth'(FnLocRem): remoteNow = inSync_q[i];
        default: ;
      endcase
    end
  end

  // start and stop come from the inputs only when the active source
  // of the present mode is set to the digital inputs
  assign cmdFromDi = remoteNow ? srcIsDigital(remSrc_q)
                               : srcIsDigital(locSrc_q);

  // every assigned enable input must be closed; none assigned means no check
  always_comb begin
    anyEnable = 1'b0;
    enableOk = 1'b1;
    for (int i = 0; i < NIn; i++) begin
      if (isFn(fnSel_q[i], FnGenEnable)) begin
        anyEnable = 1'b1;
        enableOk = enableOk & inSync_q[i];
      end
    end
  end

  // decode every input against its selected function
  always_comb begin
    logic anyBrake;
    logic anyTherm;
    anyBrake = 1'b0;
    anyTherm = 1'b0;
    cmd_d = '0;
    cmd_d.remoteSel = remoteNow;
    cmd_d.brakeAllow = 1'b1;
    cmd_d.fwdContactor = 1'b1;
    for (int i = 0; i < NIn; i++) begin
      // several jog inputs combine as an or
      if (isFn(fnSel_q[i], FnJog)) begin
        cmd_d.jog = cmd_d.jog | inSync_q[i];
      end
      // open keeps forward; the two contactors never close together
      if (isFn(fnSel_q[i], FnFwdRev)) begin
        cmd_d.fwdContactor = !inSync_q[i];
        cmd_d.revContactor = inSync_q[i];
      end
      // fault and alarm contacts are closed in the healthy state
      if (isFn(fnSel_q[i], FnNoExtFault)) begin
        cmd_d.extFault = cmd_d.extFault | !inSync_q[i];
      end
      // the alarm only reports; nothing here stops the motor for it
      if (isFn(fnSel_q[i], FnNoExtAlarm)) begin
        cmd_d.extAlarm = cmd_d.extAlarm | !inSync_q[i];
      end
      // any one open brake input withdraws the permission at once
      if (isFn(fnSel_q[i], FnBrake)) begin
        anyBrake = 1'b1;
        cmd_d.brakeAllow = cmd_d.brakeAllow & inSync_q[i];
      end
      // edge only, so a button held closed cannot reset again
      if (isFn(fnSel_q[i], FnReset)) begin
        cmd_d.faultReset = cmd_d.faultReset |
          closedEdge(inSync_q[i], inPrev_q[i]);
      end
      // emergency run ignores source, enable and protections alike
      if (isFn(fnSel_q[i], FnEmergency)) begin
        cmd_d.emergencyRun = inSync_q[i];
      end
      // a load needs the matching saved flag and a motor not enabled
      if (isFn(fnSel_q[i], FnLoadUser) && !motorEnabled) begin
        cmd_d.loadUser1 = cmd_d.loadUser1 |
          (closedEdge(inSync_q[i], inPrev_q[i]) & saved1_q);
        cmd_d.loadUser2 = cmd_d.loadUser2 |
          (openedEdge(inSync_q[i], inPrev_q[i]) & saved2_q);
      end
      // start commands need a digital source and every enable closed
      if (cmdFromDi && enableOk && isFn(fnSel_q[i], FnStartStop)) begin
        cmd_d.runCmd = inSync_q[i];
      end
      if (cmdFromDi && enableOk && isFn(fnSel_q[i], FnStart3w)) begin
        cmd_d.start3wPulse = cmd_d.start3wPulse |
          closedEdge(inSync_q[i], inPrev_q[i]);
      end
      // a stop is never held back by the enable inputs
      if (cmdFromDi && isFn(fnSel_q[i], FnStop3w)) begin
        cmd_d.stop3wPulse = cmd_d.stop3wPulse |
          openedEdge(inSync_q[i], inPrev_q[i]);
      end
    end
    // no brake input assigned means no braking permission
    if (!anyBrake) begin
      cmd_d.brakeAllow = 1'b0;
    end
    cmd_d.fastStop = anyEnable & !enableOk;
    // last input doubles as the thermistor channel
    anyTherm = isFn(fnSel_q[NIn-1], FnThermAlarm) ||
               isFn(fnSel_q[NIn-1], FnThermFault);
    if (anyTherm) begin
      cmd_d.thermShort = thSync_q[2];
      if (isFn(fnSel_q[NIn-1], FnThermFault)) begin
        cmd_d.thermFault = thTripped_q;
      end else begin
        cmd_d.thermAlarm = thTripped_q;
      end
    end
  end

  // outputs come straight from flip-flops, one cycle after decode
  // the extra stage keeps decode glitches off the starter's wires
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd_d;
    end
  end
  assign cmd = cmd_q;

  // apb: every access answers in its first access cycle
  // a write lands at the edge that ends that cycle
  assign access = psel && penable;

  always_comb begin
    rdMux = '0;
    addrOk = 1'b0;
    // one word per function select, upper bits read zero
    for (int i = 0; i < NIn; i++) begin
      if (paddr == fnAddr(i)) begin
        rdMux = 32'(fnSel_q[i]);
        addrOk = 1'b1;
      end
    end
    // command sources and saved flags share one word
    if (paddr == AddrCmdCfg) begin
      addrOk = 1'b1;
      rdMux[CfgLocSrcLsb +: 3] = locSrc_q;
      rdMux[CfgRemSrcLsb +: 3] = remSrc_q;
      rdMux[CfgSaved1Bit] = saved1_q;
      rdMux[CfgSaved2Bit] = saved2_q;
    end
    // the registered command word, as the starter sees it
    if (paddr == AddrStatus) begin
      addrOk = 1'b1;
      rdMux = 32'(cmd_q);
    end
    // every synchronised level shows here, whatever its function
    if (paddr == AddrInputs) begin
      addrOk = 1'b1;
      rdMux = 32'(inSync_q); // status shows every level
    end
  end

  // ready answers every setup cycle: zero wait states, one cycle high
  // a master that skips the setup cycle gets no answer at all
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
    end
  end

  // unmapped addresses answer with an error alongside ready
  // a write there changes nothing, a read there returns zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= psel && !penable && !addrOk;
    end
  end

  // read data is taken from the mux during setup
  // zero between reads keeps stale words off the bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= (psel && !penable && !pwrite) ? rdMux : '0;
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // function selects; writes land with pready high
  // software must keep single-use functions on one input only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NIn; i++) begin
        fnSel_q[i] <= (i == 0) ? RstFnSel1 :
                      (i == 1) ? RstFnSel2 : RstFnSelOther;
      end
    end else if (access && pready_q && pwrite) begin
      for (int i = 0; i < NIn; i++) begin
        if (paddr == fnAddr(i)) begin
          fnSel_q[i] <= pwdata[FnWidth-1:0];
        end
      end
    end
  end

  // command sources; reset leaves remote on the digital inputs
  // and local on the keypad
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locSrc_q <= '0;
      remSrc_q <= CmdSrcDigital;
    end else if (access && pready_q && pwrite && paddr == AddrCmdCfg) begin
      locSrc_q <= pwdata[CfgLocSrcLsb +: 3];
      remSrc_q <= pwdata[CfgRemSrcLsb +: 3];
    end
  end

  // saved flags stand for memory saves done by action codes four and five;
  // a limitation: nothing here checks that a save really took place
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      saved1_q <= 1'b0;
      saved2_q <= 1'b0;
    end else if (access && pready_q && pwrite && paddr == AddrCmdCfg) begin
      saved1_q <= pwdata[CfgSaved1Bit];
      saved2_q <= pwdata[CfgSaved2Bit];
    end
  end

endmodule // dinmap_top

`default_nettype wire

// File: tb/dinmap_checker.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the input mapper
module dinmap_checker
  import dinmap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic motorEnabled,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire dinmap_cmd_t cmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // zero wait states; an error only rides on a ready
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_err_a: assert property (pslverr |-> pready && $past(psel))
    else $error("error without ready");
  // outputs stay quiet on the first edge out of reset
  reset_quiet_a: assert property (!$past(rst_n) |-> cmd == '0 && !pready)
    else $error("output active after reset");
  // once decode has settled exactly one contactor is closed
  contactor_excl_a: assert property (
    $past(rst_n, 3) |-> cmd.fwdContactor ^ cmd.revContactor)
    else $error("contactors not opposed");
  // an open enable never leaves a run command standing
  fast_stop_a: assert property (
    cmd.fastStop |-> !cmd.runCmd) else $error("run during fast stop");
  // transition events last one cycle only
  start_once_a: assert property (
    cmd.start3wPulse |=> !cmd.start3wPulse) else $error("start repeats");
  stop_once_a: assert property (
    cmd.stop3wPulse |=> !cmd.stop3wPulse) else $error("stop repeats");
  reset_once_a: assert property (
    cmd.faultReset |=> !cmd.faultReset) else $error("reset repeats");
  load_one_a: assert property (
    cmd.loadUser1 |=> !cmd.loadUser1) else $error("load one repeats");
  load_two_a: assert property (
    cmd.loadUser2 |=> !cmd.loadUser2) else $error("load two repeats");
  load_block_a: assert property (
    cmd.loadUser1 || cmd.loadUser2 |-> !$past(motorEnabled))
    else $error("load while motor enabled");
endmodule // dinmap_checker

bind dinmap_top dinmap_checker dinmap_checker_i (.clk(clk), .rst_n(rst_n),
  .motorEnabled(motorEnabled), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cmd(cmd));
`default_nettype wire

// File: tb/dinmap_field_model.sv
`timescale 1ns/10ps
`default_nettype none
// switches and thermistor comparators; levels move just after an edge
module dinmap_field_model (
  input wire logic clk,
  output logic [5:0] pins,
  output logic over,
  output logic rel,
  output logic shrt
);
  // idle thermistor near one kilo-ohm: released, no short
  initial {pins, over, rel, shrt} = 9'h002;
  task automatic set(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
  endtask
  task automatic therm(input logic o, input logic r, input logic s);
    @(posedge clk);
    {over, rel, shrt} <= {o, r, s};
  endtask
endmodule // dinmap_field_model
`default_nettype wire

// File: tb/dinmap_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module dinmap_top_tb;
  import dinmap_pkg::*;
  logic clk = 0, rst_n = 0, motorEnabled = 0, er;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic over, rel, shrt;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [5:0] pins;
  logic [4:0] pv;
  dinmap_cmd_t cmd;
  int bad_count = 0, n_compared = 0, pc[5];
  logic [4:0] rv[6] = '{5'h02, 5'h03, 5'h00, 5'h00, 5'h00, 5'h00};
  always #5 clk = ~clk;
  // event pulses are counted so a repeat cannot hide
  assign pv = {cmd.loadUser2, cmd.loadUser1, cmd.faultReset,
    cmd.stop3wPulse, cmd.start3wPulse};
  always @(posedge clk)
    if (rst_n) for (int k = 0; k < 5; k++) pc[k] += pv[k];
  dinmap_field_model dinmap_field_model_i (.clk(clk), .pins(pins),
    .over(over), .rel(rel), .shrt(shrt));
  dinmap_top dinmap_top_i (.clk(clk), .rst_n(rst_n), .digitalInputN(pins),
    .thermOverTrip(over), .thermUnderRelease(rel), .thermUnderShort(shrt),
    .motorEnabled(motorEnabled), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd(cmd));
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request stands until ready is sampled; the wait is bounded
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      bad_count++;
      stop_test();
    end
    {psel, penable} <= 2'b00;
  endtask
  task automatic fn(input int i, input dinmap_fn_t f);
    apb(1'b1, AddrFnSel0 + 12'(4 * i), 32'(f));
  endtask
  // the input decode path takes three edges, the thermistor path four; six leaves margin
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic pin(input int i, input logic v);
    dinmap_field_model_i.set(i, v);
    settle();
  endtask
  task automatic lvl(input dinmap_fn_t f, input logic v, input int b);
    fn(2, f);
    pin(2, v);
    `CHK(cmd[b], 1'b1)
  endtask
  task automatic cfg(input logic [31:0] d);
    apb(1'b1, AddrCmdCfg, d);
    settle();
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, AddrFnSel0 + 12'(4 * i), '0);
      `CHK(rd, 32'(rv[i]))
    end
    apb(1'b0, AddrCmdCfg, '0);
    `CHK(rd, 32'h0000_0010)
    apb(1'b1, 12'h024, '1);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h024, '0);
    `CHK(rd, 32'h0000_0000)
    // three-wire refused from a non-digital source, then accepted
    pin(1, 1'b1);
    pin(0, 1'b1);
    `CHK(pc[0], 0)
    pin(0, 1'b0);
    cfg(32'h0000_0311);
    pin(0, 1'b1);
    settle();
    `CHK(pc[0], 1)
    pin(1, 1'b0);
    `CHK(pc[1], 1)
    fn(0, FnStartStop);
    fn(1, FnGenEnable);
    settle();
    `CHK({cmd.runCmd, cmd.fastStop}, 2'b01)
    pin(1, 1'b1);
    `CHK(cmd.runCmd, 1'b1)
    cfg(32'h0000_0310);
    `CHK(cmd.runCmd, 1'b0)
    cfg(32'h0000_0311);
    lvl(FnLocRem, 1'b1, 13);
    pin(2, 1'b0);
    `CHK(cmd.remoteSel, 1'b0)
    lvl(FnJog, 1'b1, 12);
    lvl(FnFwdRev, 1'b0, 11);
    lvl(FnFwdRev, 1'b1, 10);
    lvl(FnNoExtFault, 1'b0, 9);
    lvl(FnNoExtAlarm, 1'b0, 8);
    lvl(FnNoExtAlarm, 1'b0, 17);
    lvl(FnBrake, 1'b1, 7);
    fn(3, FnBrake);
    settle();
    `CHK(cmd.brakeAllow, 1'b0)
    fn(3, FnReset);
    pin(3, 1'b1);
    settle();
    `CHK(pc[2], 1)
    fn(3, FnLoadUser);
    pin(3, 1'b0);
    `CHK(pc[4], 1)
    pin(3, 1'b1);
    `CHK(pc[3], 1)
    @(posedge clk) motorEnabled <= 1'b1;
    pin(3, 1'b0);
    `CHK(pc[4], 1)
    @(posedge clk) motorEnabled <= 1'b0;
    cfg(32'h0000_0011);
    pin(3, 1'b1);
    `CHK(pc[3], 1)
    fn(4, FnEmergency);
    pin(1, 1'b0);
    pin(4, 1'b1);
    `CHK(cmd.emergencyRun, 1'b1)
    fn(4, FnNone);
    apb(1'b0, AddrInputs, '0);
    `CHK(rd[5:0], pins)
    fn(5, FnThermFault);
    dinmap_field_model_i.therm(1'b1, 1'b0, 1'b0);
    settle();
    `CHK(cmd.thermFault, 1'b1)
    dinmap_field_model_i.therm(1'b0, 1'b0, 1'b0);
    settle();
    `CHK(cmd.thermFault, 1'b1)
    dinmap_field_model_i.therm(1'b0, 1'b1, 1'b1);
    settle();
    `CHK({cmd.thermFault, cmd.thermShort}, 2'b11)
    dinmap_field_model_i.therm(1'b0, 1'b1, 1'b0);
    settle();
    `CHK({cmd.thermFault, cmd.thermShort}, 2'b00)
    fn(5, FnThermAlarm);
    dinmap_field_model_i.therm(1'b1, 1'b0, 1'b0);
    settle();
    `CHK({cmd.thermAlarm, cmd.thermFault}, 2'b10)
    apb(1'b0, AddrStatus, '0);
    `CHK(rd[2], 1'b1)
    stop_test();
  end
endmodule // dinmap_top_tb
`default_nettype wire
